// ===== dpp_top.sv
// dpp_top: pin control for a bus control port and an irq port
// assumes: apb master on pclk; pins are plain board levels
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - bus port select bit one gives pin to bus control, zero makes it io
// - bus port select loads ones or zeros from its strap at reset end
// - irq port select bit one makes pin an irq input, zero makes it io
// - irq port select loads ones or zeros from its strap at reset end
// - for io pins direction one enables the driver, zero leaves input
// - data writes update a latch driven onto io output pins
// - data reads give pin level for io inputs, latch otherwise
// - each data register answers at two aliased addresses once the straps have loaded
// - bus port direction register is read and written at any time once the straps have loaded
// - clock mode strap has no effect once the straps have loaded
module dpp_top
#(
  parameter int unsigned W = dpp_pkg::PORT_W
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         bus_port_reset_strap,
  input  wire logic         irq_port_reset_strap,
  input  wire logic         clock_mode_strap,
  input  wire logic [W-1:0] bus_port_pin_in,
  output logic      [W-1:0] bus_port_pin_out,
  output logic      [W-1:0] bus_port_pin_oe,
  input  wire logic [W-1:0] irq_port_pin_in,
  output logic      [W-1:0] irq_port_pin_out,
  output logic      [W-1:0] irq_port_pin_oe,
  input  wire logic [W-1:0] bus_ctl_func_out,
  input  wire logic [W-1:0] bus_ctl_func_oe,
  output logic      [W-1:0] bus_ctl_func_in,
  output logic      [W-1:0] irq_req
);

  // address decode shared by read and write paths
  function automatic dpp_pkg::dpp_reg_t dec(input logic [7:0] a);
    unique case (a)
      dpp_pkg::OFS_BUS_FSEL:  dec = dpp_pkg::DPP_R_BUS_FSEL;
      dpp_pkg::OFS_BUS_DIR:   dec = dpp_pkg::DPP_R_BUS_DIR;
      dpp_pkg::OFS_BUS_DATA,
      dpp_pkg::OFS_BUS_DATA2: dec = dpp_pkg::DPP_R_BUS_DATA;
      dpp_pkg::OFS_IRQ_FSEL:  dec = dpp_pkg::DPP_R_IRQ_FSEL;
      dpp_pkg::OFS_IRQ_DIR:   dec = dpp_pkg::DPP_R_IRQ_DIR;
      dpp_pkg::OFS_IRQ_DATA,
      dpp_pkg::OFS_IRQ_DATA2: dec = dpp_pkg::DPP_R_IRQ_DATA;
      dpp_pkg::OFS_STATUS:    dec = dpp_pkg::DPP_R_STATUS;
      default:                dec = dpp_pkg::DPP_R_NONE;
    endcase
  endfunction : dec

  // read value of a data register
  function automatic logic [W-1:0] data_rd(input logic [W-1:0] fsel,
                                           input logic [W-1:0] dir,
                                           input logic [W-1:0] lat,
                                           input logic [W-1:0] lvl);
    data_rd = (~fsel & ~dir & lvl) | ((fsel | dir) & lat);
  endfunction : data_rd

  // select value that a strap level asks for at reset end
  function automatic logic [W-1:0] strap_sel(input logic lvl);
    strap_sel = lvl ? dpp_pkg::FSEL_ALL_FUNC : dpp_pkg::FSEL_ALL_IO;
  endfunction : strap_sel

  logic [W-1:0]  bus_fsel_r, bus_fsel_nxt;
  logic [W-1:0]  bus_dir_r, bus_dir_nxt;
  logic [W-1:0]  bus_data_r, bus_data_nxt;
  logic [W-1:0]  irq_fsel_r, irq_fsel_nxt;
  logic [W-1:0]  irq_dir_r, irq_dir_nxt;
  logic [W-1:0]  irq_data_r, irq_data_nxt;
  logic          done_r, done_nxt;
  logic          ckmod_r, ckmod_nxt;
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pready_r, pready_nxt;
  logic          pslverr_r, pslverr_nxt;
  logic [W-1:0]  func_in_r, func_in_nxt;
  logic [W-1:0]  irq_req_r, irq_req_nxt;
  logic [W-1:0]  bus_fn_oe;
  logic          strap_load;
  logic          bus_strap;
  logic          irq_strap;
  logic          ckmod_strap;
  logic [W-1:0]  bus_lvl;
  logic [W-1:0]  irq_lvl;
  logic          wr_ev;
  dpp_pkg::dpp_reg_t sel;

  dpp_strap u_strap
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .ce                   (ce),
    .bus_port_reset_strap (bus_port_reset_strap),
    .irq_port_reset_strap (irq_port_reset_strap),
    .clock_mode_strap     (clock_mode_strap),
    .load                 (strap_load),
    .bus_strap            (bus_strap),
    .irq_strap            (irq_strap),
    .ckmod_strap          (ckmod_strap)
  );

  dpp_port #(.W(W)) u_bus_port
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .pin_in    (bus_port_pin_in),
    .fsel      (bus_fsel_r),
    .dir       (bus_dir_r),
    .data      (bus_data_r),
    .func_out  (bus_ctl_func_out),
    .func_oe   (bus_fn_oe),
    .pin_level (bus_lvl),
    .pin_out   (bus_port_pin_out),
    .pin_oe    (bus_port_pin_oe)
  );

  // irq pins are always inputs while assigned to their function
  dpp_port #(.W(W)) u_irq_port
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .pin_in    (irq_port_pin_in),
    .fsel      (irq_fsel_r),
    .dir       (irq_dir_r),
    .data      (irq_data_r),
    .func_out  ({W{1'b0}}),
    .func_oe   ({W{1'b0}}),
    .pin_level (irq_lvl),
    .pin_out   (irq_port_pin_out),
    .pin_oe    (irq_port_pin_oe)
  );

  assign sel   = dec(paddr);
  // a write lands at the access edge that sees pready high
  assign wr_ev = psel & penable & pready_r & pwrite;

  // no function drive before the straps have settled each pin's role,
  // since the select reads all ones until then
  always_comb
  begin
    bus_fn_oe = {W{1'b0}};
    if (done_r)
      bus_fn_oe = bus_ctl_func_oe;
  end

  // register file
  always_comb
  begin
    bus_fsel_nxt = bus_fsel_r;
    bus_dir_nxt  = bus_dir_r;
    bus_data_nxt = bus_data_r;
    irq_fsel_nxt = irq_fsel_r;
    irq_dir_nxt  = irq_dir_r;
    irq_data_nxt = irq_data_r;
    done_nxt     = done_r;
    ckmod_nxt    = ckmod_r;
    // strap load wins over a same-cycle bus write
    if (strap_load)
    begin
      bus_fsel_nxt = strap_sel(bus_strap);
      irq_fsel_nxt = strap_sel(irq_strap);
      ckmod_nxt    = ckmod_strap;  // captured once, only read back in status
      done_nxt     = 1'b1;
    end
    else if (wr_ev)
    begin
      unique case (sel)
        dpp_pkg::DPP_R_BUS_FSEL: bus_fsel_nxt = pwdata[W-1:0];
        dpp_pkg::DPP_R_BUS_DIR:  bus_dir_nxt  = pwdata[W-1:0];
        dpp_pkg::DPP_R_BUS_DATA: bus_data_nxt = pwdata[W-1:0];
        dpp_pkg::DPP_R_IRQ_FSEL: irq_fsel_nxt = pwdata[W-1:0];
        dpp_pkg::DPP_R_IRQ_DIR:  irq_dir_nxt  = pwdata[W-1:0];
        dpp_pkg::DPP_R_IRQ_DATA: irq_data_nxt = pwdata[W-1:0];
        // status is read only; writes there and to holes are dropped
        dpp_pkg::DPP_R_STATUS,
        dpp_pkg::DPP_R_NONE:     ;
      endcase
    end
  end

  // all state holds while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_fsel_r <= dpp_pkg::FSEL_ALL_FUNC;
      bus_dir_r  <= dpp_pkg::DIR_RST;
      bus_data_r <= dpp_pkg::DATA_RST;
      irq_fsel_r <= dpp_pkg::FSEL_ALL_FUNC;
      irq_dir_r  <= dpp_pkg::DIR_RST;
      irq_data_r <= dpp_pkg::DATA_RST;
      done_r     <= 1'b0;
      ckmod_r    <= 1'b0;
    end
    else if (ce)
    begin
      bus_fsel_r <= bus_fsel_nxt;
      bus_dir_r  <= bus_dir_nxt;
      bus_data_r <= bus_data_nxt;
      irq_fsel_r <= irq_fsel_nxt;
      irq_dir_r  <= irq_dir_nxt;
      irq_data_r <= irq_data_nxt;
      done_r     <= done_nxt;
      ckmod_r    <= ckmod_nxt;
    end
  end

  // apb answer: one wait-free access cycle, held off until straps load
  always_comb
  begin
    pready_nxt  = psel & ~pready_r & done_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (pready_nxt)
    begin
      prdata_nxt  = '0;
      pslverr_nxt = 1'b0;
      unique case (sel)
        dpp_pkg::DPP_R_BUS_FSEL: prdata_nxt[W-1:0] = bus_fsel_r;
        dpp_pkg::DPP_R_BUS_DIR:  prdata_nxt[W-1:0] = bus_dir_r;
        dpp_pkg::DPP_R_BUS_DATA: prdata_nxt[W-1:0] =
          data_rd(bus_fsel_r, bus_dir_r, bus_data_r, bus_lvl);
        dpp_pkg::DPP_R_IRQ_FSEL: prdata_nxt[W-1:0] = irq_fsel_r;
        dpp_pkg::DPP_R_IRQ_DIR:  prdata_nxt[W-1:0] = irq_dir_r;
        dpp_pkg::DPP_R_IRQ_DATA: prdata_nxt[W-1:0] =
          data_rd(irq_fsel_r, irq_dir_r, irq_data_r, irq_lvl);
        dpp_pkg::DPP_R_STATUS:
        begin
          prdata_nxt[dpp_pkg::STAT_DONE_BIT]  = done_r;
          prdata_nxt[dpp_pkg::STAT_CKMOD_BIT] = ckmod_r;
        end
        dpp_pkg::DPP_R_NONE:     pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (ce)
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // dedicated function inputs seen only on assigned pins, and only once
  // the straps have settled which pins those are
  always_comb
  begin
    func_in_nxt = {W{1'b0}};
    irq_req_nxt = {W{1'b0}};
    if (done_r)
    begin
      func_in_nxt = bus_lvl & bus_fsel_r;
      irq_req_nxt = irq_lvl & irq_fsel_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_in_r <= '0;
      irq_req_r <= '0;
    end
    else if (ce)
    begin
      func_in_r <= func_in_nxt;
      irq_req_r <= irq_req_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign bus_ctl_func_in = func_in_r;
  assign irq_req         = irq_req_r;

endmodule : dpp_top
`default_nettype wire

// ===== dpp_pkg.sv
// dpp_pkg: shared constants for the dual port pin control block
// assumes: registers reached over apb, one aligned 32-bit word each
package dpp_pkg;

  localparam int unsigned PORT_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_BUS_FSEL  = 8'h00;
  localparam logic [7:0] OFS_BUS_DIR   = 8'h04;
  localparam logic [7:0] OFS_BUS_DATA  = 8'h08;
  localparam logic [7:0] OFS_BUS_DATA2 = 8'h0c;
  localparam logic [7:0] OFS_IRQ_FSEL  = 8'h10;
  localparam logic [7:0] OFS_IRQ_DIR   = 8'h14;
  localparam logic [7:0] OFS_IRQ_DATA  = 8'h18;
  localparam logic [7:0] OFS_IRQ_DATA2 = 8'h1c;
  localparam logic [7:0] OFS_STATUS    = 8'h20;

  // status register fields
  localparam int unsigned STAT_DONE_BIT  = 0;
  localparam int unsigned STAT_CKMOD_BIT = 1;

  // reset values
  localparam logic [7:0] FSEL_ALL_FUNC = 8'hff;
  localparam logic [7:0] FSEL_ALL_IO   = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic [7:0] DATA_RST      = 8'h00;

  // edges after reset release before straps are trusted
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  typedef enum logic [3:0] {
    DPP_R_BUS_FSEL,
    DPP_R_BUS_DIR,
    DPP_R_BUS_DATA,
    DPP_R_IRQ_FSEL,
    DPP_R_IRQ_DIR,
    DPP_R_IRQ_DATA,
    DPP_R_STATUS,
    DPP_R_NONE
  } dpp_reg_t;

endpackage : dpp_pkg

// ===== dpp_strap.sv
// dpp_strap: samples the reset straps after reset release
// assumes: straps are board levels held steady around reset release
`timescale 1ns/1ns
`default_nettype none
module dpp_strap
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic bus_port_reset_strap,
  input  wire logic irq_port_reset_strap,
  input  wire logic clock_mode_strap,
  output logic      load,
  output logic      bus_strap,
  output logic      irq_strap,
  output logic      ckmod_strap
);

  logic [2:0] s1_r, s2_r, s3_r;
  logic [2:0] s1_nxt, s2_nxt, s3_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic       load_r, load_nxt;

  always_comb
  begin
    s1_nxt   = {clock_mode_strap, irq_port_reset_strap,
                bus_port_reset_strap};
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    cnt_nxt  = cnt_r;
    load_nxt = 1'b0;
    if (cnt_r != dpp_pkg::STRAP_SETTLE)
    begin
      // counts only while the last two stages agree
      if (s2_r == s3_r)
        cnt_nxt = cnt_r + 3'h1;
      load_nxt = (cnt_r + 3'h1 == dpp_pkg::STRAP_SETTLE) &&
                 (s2_r == s3_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r   <= 3'h7;
      s2_r   <= 3'h7;
      s3_r   <= 3'h7;
      cnt_r  <= 3'h0;
      load_r <= 1'b0;
    end
    else if (ce)
    begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      cnt_r  <= cnt_nxt;
      load_r <= load_nxt;
    end
  end

  assign load        = load_r;
  assign bus_strap   = s3_r[0];
  assign irq_strap   = s3_r[1];
  assign ckmod_strap = s3_r[2];

endmodule : dpp_strap
`default_nettype wire

// ===== dpp_port.sv
// dpp_port: pin synchroniser and registered driver for one port
// assumes: fsel, dir, data and function drive come from pclk logic
`timescale 1ns/1ns
`default_nettype none
module dpp_port
#(
  parameter int unsigned W = 8
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] fsel,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] data,
  input  wire logic [W-1:0] func_out,
  input  wire logic [W-1:0] func_oe,
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);

  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [W-1:0] lvl_nxt, out_r, out_nxt, oe_r, oe_nxt;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_comb
      begin
        lvl_nxt[i] = lvl_r[i];
        if (s2_r[i] == s3_r[i])
          lvl_nxt[i] = s3_r[i];
        if (fsel[i])
        begin
          // dedicated function owns the driver
          out_nxt[i] = func_out[i];
          oe_nxt[i]  = func_oe[i];
        end
        else
        begin
          out_nxt[i] = data[i];
          oe_nxt[i]  = dir[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
      out_r <= '0;
      oe_r  <= '0;
    end
    else if (ce)
    begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign pin_level = lvl_r;
  assign pin_out   = out_r;
  assign pin_oe    = oe_r;

endmodule : dpp_port
`default_nettype wire

// ===== dpp_top_props.sv
// dpp_top_props: apb and pin timing checks on dpp_top ports
// assumes: bound into every dpp_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module dpp_top_props
#(
  parameter int unsigned W = 8
)
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [W-1:0] irq_port_pin_out,
  input wire logic [W-1:0] irq_port_pin_oe,
  input wire logic [W-1:0] irq_req
);
  logic [3:0] up_r;
  logic [3:0] up_nxt;
  logic       wr_acc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_acc = psel & penable & pready & pwrite;
  // cycles since reset release, saturating
  always_comb up_nxt = (up_r == 4'hf) ? up_r : up_r + 4'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_r <= 4'h0;
    else
      up_r <= up_nxt;
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_reset_quiet: assert property ($rose(presetn) |->
    (!pready && irq_port_pin_oe == '0) [*4])
    else $error("answer or drive too soon after reset");
  a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > 8'h20))
    else $error("pslverr wrong for address");
  a_err_holds: assert property (!pready |-> $stable(pslverr))
    else $error("pslverr moved between answers");
  a_upper_zero: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_irq_write_only: assert property (up_r == 4'hf &&
    ($changed(irq_port_pin_out) || $changed(irq_port_pin_oe)) |->
    $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
    else $error("irq pin drive moved without a write");
  a_irq_undriven: assert property (~|(irq_req & irq_port_pin_oe))
    else $error("irq input pin is driven");
  c_write: cover property (wr_acc);
  c_error: cover property (pready && pslverr);
  c_irq: cover property (irq_req != '0);
endmodule : dpp_top_props
bind dpp_top dpp_top_props #(.W(W)) dpp_top_props_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_port_pin_out(irq_port_pin_out), .irq_port_pin_oe(irq_port_pin_oe),
  .irq_req(irq_req));
`default_nettype wire

// ===== dpp_board.sv
// dpp_board: pins and board devices around the block
// assumes: ext_lvl is what the board puts on pins the block leaves
`timescale 1ns/1ns
`default_nettype none
module dpp_board
#(
  parameter int unsigned W = 8
)
(
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] ext_lvl,
  output logic      [W-1:0] pin_in
);
  // driven pins carry the block's level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : dpp_board
`default_nettype wire

// ===== test_dual_port_pin_control.sv
// test_dual_port_pin_control: random register and pin traffic over apb
// assumes: dpp_top, dpp_board and the bound checker compiled before
`timescale 1ns/1ns
`default_nettype none
module test_dual_port_pin_control;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        bstrap, istrap, ckstrap, ce;
  logic [7:0]  paddr, bpo, boe, ipo, ioe, fout, foe, fin, irq, ef, ei;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pins, ext;
  logic [7:0]  fs [2];
  logic [7:0]  dr [2];
  logic [7:0]  lt [2];
  int          n_fail, compares, seed;
  dpp_top dpp_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_port_reset_strap(bstrap), .irq_port_reset_strap(istrap),
    .clock_mode_strap(ckstrap), .bus_port_pin_in(pins[7:0]),
    .bus_port_pin_out(bpo), .bus_port_pin_oe(boe),
    .irq_port_pin_in(pins[15:8]), .irq_port_pin_out(ipo),
    .irq_port_pin_oe(ioe), .bus_ctl_func_out(fout), .bus_ctl_func_oe(foe),
    .bus_ctl_func_in(fin), .irq_req(irq));
  dpp_board #(.W(16)) dpp_board_inst (.pin_out({ipo, bpo}),
    .pin_oe({ioe, boe}), .ext_lvl(ext), .pin_in(pins));
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [7:0] ra(input int p, input int k);
    return (p == 1 ? dpp_pkg::OFS_IRQ_FSEL : dpp_pkg::OFS_BUS_FSEL)
           + 8'(4 * k);
  endfunction : ra
  function automatic logic [7:0] eoe(input int p);
    if (p == 1)
      return ~fs[1] & dr[1];
    return (fs[0] & foe) | (~fs[0] & dr[0]);
  endfunction : eoe
  function automatic logic [7:0] eout(input int p);
    if (p == 1)
      return lt[1];
    return (fs[0] & fout) | (~fs[0] & lt[0]);
  endfunction : eout
  function automatic logic [7:0] lvl(input int p);
    return (eoe(p) & eout(p)) | (~eoe(p) & ext[8*p +: 8]);
  endfunction : lvl
  function automatic logic [7:0] edat(input int p);
    return (~fs[p] & ~dr[p] & lvl(p)) | ((fs[p] | dr[p]) & lt[p]);
  endfunction : edat
  task automatic wr(input int p, input int k, input logic [7:0] v);
    apb(1'b1, ra(p, k), {24'($random(seed)), v});
    if (k == 0)
      fs[p] = v;
    else if (k == 1)
      dr[p] = v;
    else
      lt[p] = v;
  endtask : wr
  task automatic check_all();
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b0, ra(p, 0), 32'h0);
      chk("fsel", rd[7:0], fs[p]);
      apb(1'b0, ra(p, 1), 32'h0);
      chk("dir", rd[7:0], dr[p]);
      for (int k = 2; k < 4; k++)
      begin
        apb(1'b0, ra(p, k), 32'h0);
        chk("data", rd[7:0], edat(p));
      end
    end
    chk("bus_oe", boe, eoe(0));
    chk("bus_out", bpo & boe, eout(0) & eoe(0));
    chk("irq_oe", ioe, eoe(1));
    chk("irq_out", ipo & ioe, eout(1) & eoe(1));
    chk("ctl_in", fin, fs[0] & lvl(0));
    chk("irq_req", irq, fs[1] & lvl(1));
  endtask : check_all
  task automatic reset_dut(input logic b, input logic i, input logic c);
    presetn <= 1'b0;
    bstrap <= b;
    istrap <= i;
    ckstrap <= c;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    fs[0] = {8{b}};
    fs[1] = {8{i}};
    dr = '{8'h00, 8'h00};
    lt = '{8'h00, 8'h00};
  endtask : reset_dut
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
  initial
  begin
    seed = 11243;
    n_fail = 0;
    compares = 0;
    ce = 1'b1;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {bstrap, istrap, ckstrap, fout, foe, ext} = '0;
    for (int r = 0; r < 2; r++)
    begin
      reset_dut(r == 0, r == 1, r == 0);
      ext <= 16'($random(seed));
      repeat (6) @(posedge pclk);
      check_all();
      ckstrap <= ~ckstrap;
      apb(1'b1, dpp_pkg::OFS_STATUS, 32'h0);
      apb(1'b0, dpp_pkg::OFS_STATUS, 32'h0);
      chk("status", rd[7:0], {6'h0, r == 0, 1'b1});
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped", {er, rd[6:0]}, 8'h80);
      wr(0, 1, 8'hff);
      wr(1, 1, 8'ha5);
      wr(1, 3, 8'h3c);
      wr(0, 0, 8'h0f);
      repeat (6) @(posedge pclk);
      check_all();
      ef = fs[0] & lvl(0);
      ei = fs[1] & lvl(1);
      ce <= 1'b0;
      ext <= ~ext;
      repeat (6) @(posedge pclk);
      chk("frozen_in", fin, ef);
      chk("frozen_irq", irq, ei);
      ce <= 1'b1;
      for (int n = 0; n < 30; n++)
      begin
        fout <= 8'($random(seed));
        foe <= 8'($random(seed));
        ext <= 16'($random(seed));
        wr($random(seed) & 1, $random(seed) & 3, 8'($random(seed)));
        repeat (6) @(posedge pclk);
        check_all();
      end
      $display("test %0d done", r);
    end
    wrap_up();
  end
endmodule : test_dual_port_pin_control
`default_nettype wire
